/* File: rtl/ppfs_pkg.sv */
// Shared constants, register map and types for the push-pull fault and mode sequencer.
package ppfs_pkg;

  // Clock period of pclk.
  localparam int CLK_NS = 10;

  // Least time to cycles, rounded up, never below one cycle.
  function automatic int ns_ceil(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time to cycles, rounded down, never below one cycle.
  function automatic int ns_floor(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Timing figures and their cycle counts.
  localparam int OV_DELAY_NS = 550;
  localparam int OV_DELAY_CYC = ns_floor(OV_DELAY_NS);
  localparam int HIC_OFF_NS = 100;
  localparam int HIC_OFF_CYC = ns_ceil(HIC_OFF_NS);
  localparam int DEAD_NS = 70;
  localparam int DEAD_CYC = ns_ceil(DEAD_NS);
  localparam int EN_FILT_NS = 5000;
  localparam int EN_FILT_CYC = ns_ceil(EN_FILT_NS);
  localparam int HARD_HOLD_US = 200;
  localparam int HARD_HOLD_DEF = ns_ceil(HARD_HOLD_US * 1000);
  localparam int SYNC_LOSS_NS = 20000;
  localparam int SYNC_LOSS_DEF = ns_floor(SYNC_LOSS_NS);

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HALF = 8'h04;
  localparam logic [7:0] ADDR_DUTY = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // Control field positions and reset values.
  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_SSM_BIT = 1;
  localparam int CTRL_DUTY_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] HALF_RST = 16'h0032;
  localparam logic [15:0] DUTY_RST = 16'h0019;

  // Soft-start ramp end points.
  localparam logic [7:0] SS_FULL = 8'hFF;
  localparam logic [7:0] SS_ZERO = 8'h00;

  // Sequencer modes.
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_WAIT = 3'b001,
    ST_SOFT = 3'b010,
    ST_RUN = 3'b011,
    ST_DISCH = 3'b100
  } ppfs_state_t;

  // Comparator flags and the external clock, as they arrive on pins.
  typedef struct packed {
    logic ext_clk;
    logic clk_float;
    logic dip_hard;
    logic hs2;
    logic hs1;
    logic ilim2;
    logic ilim1;
    logic warm;
    logic hot;
    logic ov_above_fall;
    logic ov_rise;
    logic vcc_ok;
    logic enable_input;
  } ppfs_cmp_t;

  // Status word read back by software.
  typedef struct packed {
    logic hard_long;
    logic sync_lost;
    logic sync_mode;
    logic therm_stop;
    logic ov_stop;
    logic dip_hard;
    ppfs_state_t state;
  } ppfs_stat_t;

endpackage

/* File: rtl/ppfs_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module ppfs_sync
  import ppfs_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Levels in and out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

/* File: rtl/ppfs_filt.sv */
// Glitch filter: the output follows the input only after it has held steady.
`timescale 1ns/1ps
module ppfs_filt
  import ppfs_pkg::*;
#(
  parameter int CYC = 4,
  parameter int CW = 16
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Filtered level.
  input wire logic d,
  output logic q
);

  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_r;

  // Any bounce restarts the count, so short pulses never pass either way.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      q <= 1'b0;
    end
    else if (d == q)
      cnt_r <= '0;
    else if (cnt_r == LAST)
    begin
      cnt_r <= '0;
      q <= d;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end

endmodule

/* File: rtl/ppfs_sequencer.sv */
// Push-pull driver sequencer: modes, fault handling, phase and gate generation.
// Overview of operation
// R01 - Overvoltage stops both switches after 550 ns.
// R02 - Overvoltage recovery needs supply below falling threshold.
// R03 - Per-cycle current limit ends each switch's on-phase.
// R04 - Current limit ignored during soft-start, active afterwards.
// R05 - Small pin dip is soft short, large hard.
// R06 - Soft short trip: off 100 ns, retry phase.
// R07 - Retries repeat through whole on-time until clear.
// R08 - Both drives off during each retry gap.
// R09 - Hard short uses fixed 5 A comparator.
// R10 - Hard short over 200 us discharges, then restarts.
// R11 - Hard short trip acts within 65 ns.
// R12 - Enabled but supply low keeps switches inactive.
// R13 - Enable filter rejects pulses under 5 us.
// R14 - Undriven enable means disabled, stays shut down.
// R15 - Thermal stop at 180 C, resume below 147 C.
// R16 - Drains high-impedance while disabled or supply low.
// R17 - Soft-start at power-up and each enable rise.
// R18 - Run only when enabled, supplied, soft-start done.
// R19 - External clock divided by two into phases.
// R20 - Sync mode never reverts; clock loss stops switching.
// R21 - Sync mode disables duty control and spreading.
// R22 - External clock source starts after device supply.
// R23 - 70 ns dead time between the two phases.
// R24 - Floating frequency pin waits for external clock.
// R25 - Divider gives two alternating 50% phases.
// R26 - All pin flags pass two flip-flops first.
// R27 - Outputs stay off until every fault recovers.
`timescale 1ns/1ps
module ppfs_sequencer
  import ppfs_pkg::*;
#(
  parameter int HARD_HOLD_CYC = HARD_HOLD_DEF,
  parameter int SYNC_LOSS_CYC = SYNC_LOSS_DEF,
  parameter int SS_STEP_CYC = 8,
  parameter int CNT_W = 16
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator flags and external clock pin.
  input wire ppfs_cmp_t cmp_pins,
  // Switch drive and soft-start pin control.
  output logic first_switch_gate,
  output logic second_switch_gate,
  output logic drain_hiz,
  output logic ss_discharge,
  output logic [7:0] gate_strength
);

  localparam logic [CNT_W-1:0] DEAD_W = CNT_W'(DEAD_CYC);
  localparam logic [CNT_W-1:0] OV_W = CNT_W'(OV_DELAY_CYC);
  localparam logic [CNT_W-1:0] HIC_W = CNT_W'(HIC_OFF_CYC);
  localparam logic [CNT_W-1:0] HOLD_W = CNT_W'(HARD_HOLD_CYC);
  localparam logic [CNT_W-1:0] LOSS_W = CNT_W'(SYNC_LOSS_CYC);
  localparam logic [CNT_W-1:0] STEP_W = CNT_W'(SS_STEP_CYC - 1);

  // Saturating increment shared by the loss, half-period and hard-short hold counters.
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction

  ppfs_cmp_t pin_s;
  logic [$bits(ppfs_cmp_t)-1:0] pin_q;
  logic en_f;
  logic en_q_r;
  ppfs_state_t state_r;
  ppfs_state_t state_nxt;
  logic [2:0] ctrl_r;
  logic [15:0] half_r;
  logic [15:0] duty_r;
  logic [CNT_W-1:0] ov_cnt_r;
  logic ov_arm_r;
  logic ov_stop_r;
  logic therm_stop_r;
  logic sync_mode_r;
  logic sync_lost_r;
  logic ext_q_r;
  logic [CNT_W-1:0] loss_cnt_r;
  logic [CNT_W-1:0] hc_r;
  logic ph_r;
  logic [3:0] lfsr_r;
  logic [CNT_W-1:0] hic_r;
  logic cut_r;
  logic [CNT_W-1:0] hold_cnt_r;
  logic [CNT_W-1:0] step_cnt_r;
  logic [7:0] ramp_r;
  logic [31:0] rd_r;

  logic run_ok;
  logic ext_edge;
  logic sync_want;
  logic osc_ok;
  logic ssm_act;
  logic duty_act;
  logic [CNT_W-1:0] half_lim;
  logic tick;
  logic active;
  logic fault_any;
  logic win;
  logic drive;
  logic cur_ilim;
  logic cur_hs;
  logic trip_soft;
  logic trip_hard;
  logic hard_long;
  logic wr;
  logic addr_ok;

  // R26 two-stage sync
  ppfs_sync #(.W($bits(ppfs_cmp_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(cmp_pins),
    .q(pin_q)
  );
  assign pin_s = ppfs_cmp_t'(pin_q);

  // R13 enable glitch filter
  ppfs_filt #(.CYC(EN_FILT_CYC), .CW(CNT_W)) u_en_filt (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_s.enable_input),
    .q(en_f)
  );

  // Mode and clocking qualifiers.
  assign run_ok = en_f & pin_s.vcc_ok;
  assign ext_edge = pin_s.ext_clk & ~ext_q_r;
  // R24 floating pin forces sync
  assign sync_want = ctrl_r[CTRL_SYNC_BIT] | pin_s.clk_float;
  assign osc_ok = sync_mode_r | ~sync_want;
  // R21 no spreading or duty in sync
  assign ssm_act = ctrl_r[CTRL_SSM_BIT] & ~sync_mode_r;
  assign duty_act = ctrl_r[CTRL_DUTY_BIT] & ~sync_mode_r;
  assign half_lim = CNT_W'(half_r) + (ssm_act ? CNT_W'(lfsr_r[1:0]) : '0);
  // R19 each rising external edge flips phase
  assign tick = osc_ok & (sync_mode_r ? ext_edge : (hc_r >= half_lim - 1'b1));

  // R27 any latched fault blocks drive
  assign fault_any = ov_stop_r | therm_stop_r | sync_lost_r;
  assign active = (state_r == ST_SOFT) | (state_r == ST_RUN);
  // R23 dead time after every flip
  assign win = (hc_r >= DEAD_W) & (~duty_act | (hc_r < CNT_W'(duty_r)));
  // R08 retry gap keeps both off
  assign drive = active & run_ok & ~fault_any & osc_ok & win & (hic_r == '0) & ~cut_r;
  assign cur_ilim = ph_r ? pin_s.ilim2 : pin_s.ilim1;
  assign cur_hs = ph_r ? pin_s.hs2 : pin_s.hs1;
  // R05 pin dip picks the short class
  // R04 programmed limit only in run
  assign trip_soft = ~pin_s.dip_hard & (state_r == ST_RUN) & cur_ilim & drive;
  // R09 fixed hard-short comparator
  assign trip_hard = pin_s.dip_hard & cur_hs & drive;
  assign hard_long = (hold_cnt_r >= HOLD_W);

  // Enable edge memory for the soft-start trigger.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_q_r <= 1'b0;
    else
      en_q_r <= en_f;
  end

  // Mode transitions.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // R14 filter resets low, so shutdown holds
      ST_OFF:
        if (en_f)
          state_nxt = ST_WAIT;
      // R12 wait for supply
      ST_WAIT:
        if (!en_f)
          state_nxt = ST_OFF;
        else if (pin_s.vcc_ok)
          state_nxt = ST_SOFT;
      // R18 run only after ramp completes
      ST_SOFT:
        if (!run_ok)
          state_nxt = en_f ? ST_WAIT : ST_OFF;
        else if (hard_long)
          state_nxt = ST_DISCH;
        else if (ramp_r == SS_FULL)
          state_nxt = ST_RUN;
      ST_RUN:
        if (!run_ok)
          state_nxt = en_f ? ST_WAIT : ST_OFF;
        else if (hard_long)
          state_nxt = ST_DISCH;
      // R10 restart once short clears
      ST_DISCH:
        if (!run_ok)
          state_nxt = en_f ? ST_WAIT : ST_OFF;
        else if (ramp_r == SS_ZERO && !pin_s.dip_hard)
          state_nxt = ST_SOFT;
      default:
        state_nxt = ST_OFF;
    endcase
    // R17 every enable rise restarts soft-start
    if (en_f && !en_q_r && state_r != ST_OFF)
      state_nxt = ST_WAIT;
  end

  // Mode register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  // Soft-start ramp; it only climbs in soft-start, holds in run and is emptied elsewhere.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_r <= SS_ZERO;
      step_cnt_r <= '0;
    end
    // R17 gradual ramp from zero
    else if (state_r == ST_SOFT)
    begin
      if (step_cnt_r == STEP_W)
      begin
        step_cnt_r <= '0;
        if (ramp_r != SS_FULL)
          ramp_r <= ramp_r + 1'b1;
      end
      else
        step_cnt_r <= step_cnt_r + 1'b1;
    end
    else if (state_r != ST_RUN)
    begin
      ramp_r <= SS_ZERO;
      step_cnt_r <= '0;
    end
  end

  // R01 delayed overvoltage stop
  // R02 release below falling threshold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ov_arm_r <= 1'b0;
      ov_cnt_r <= '0;
      ov_stop_r <= 1'b0;
    end
    else if (ov_stop_r)
    begin
      ov_arm_r <= 1'b0;
      ov_cnt_r <= '0;
      if (!pin_s.ov_above_fall && !pin_s.ov_rise) // A standing rise beats recovery.
        ov_stop_r <= 1'b0;
    end
    else if (ov_arm_r)
    begin
      if (ov_cnt_r == OV_W - 1'b1)
        ov_stop_r <= 1'b1;
      ov_cnt_r <= ov_cnt_r + 1'b1;
    end
    else if (pin_s.ov_rise)
    begin
      ov_arm_r <= 1'b1;
      ov_cnt_r <= '0;
    end
  end

  // R15 thermal stop with hysteresis
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      therm_stop_r <= 1'b0;
    else if (pin_s.hot)
      therm_stop_r <= 1'b1;
    else if (!pin_s.warm)
      therm_stop_r <= 1'b0;
  end

  // R20 sync mode latches; loss latches too
  // Only a reset, the model of a power cycle, leaves sync mode.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_q_r <= 1'b0;
      sync_mode_r <= 1'b0;
      sync_lost_r <= 1'b0;
      loss_cnt_r <= '0;
    end
    else
    begin
      ext_q_r <= pin_s.ext_clk;
      if (sync_want && ext_edge)
        sync_mode_r <= 1'b1;
      if (!sync_mode_r || ext_edge)
        loss_cnt_r <= '0;
      else
        loss_cnt_r <= sat_inc(loss_cnt_r);
      if (sync_mode_r && loss_cnt_r >= LOSS_W)
        sync_lost_r <= 1'b1;
    end
  end

  // R25 half-period counter and phase divider
  // Dither changes only at a flip, so each half period stays whole.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hc_r <= '0;
      ph_r <= 1'b0;
      lfsr_r <= 4'h1;
    end
    else if (tick)
    begin
      hc_r <= '0;
      ph_r <= ~ph_r;
      lfsr_r <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
    end
    else
      hc_r <= sat_inc(hc_r);
  end

  // R03 trip ends the drive
  // R06 retry after off gap
  // R07 retries span the on-time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hic_r <= '0;
    else if (tick)
      hic_r <= '0;
    else if (trip_soft)
      hic_r <= HIC_W;
    else if (hic_r != '0)
      hic_r <= hic_r - 1'b1;
  end

  // R11 hard trip cuts rest of phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cut_r <= 1'b0;
    else if (tick)
      cut_r <= 1'b0;
    else if (trip_hard)
      cut_r <= 1'b1;
  end

  // R10 hard-short persistence timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_cnt_r <= '0;
    else if (!pin_s.dip_hard || !active)
      hold_cnt_r <= '0;
    else
      hold_cnt_r <= sat_inc(hold_cnt_r);
  end

  // Registered pin drives; the phase bit keeps the two gates exclusive.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_switch_gate <= 1'b0;
      second_switch_gate <= 1'b0;
      drain_hiz <= 1'b1;
      ss_discharge <= 1'b0;
      gate_strength <= SS_ZERO;
    end
    else
    begin
      first_switch_gate <= drive & ~ph_r;
      second_switch_gate <= drive & ph_r;
      // R16 tri-state while off or low
      drain_hiz <= ~run_ok | (state_r == ST_OFF) | (state_r == ST_WAIT);
      ss_discharge <= (state_r == ST_DISCH);
      gate_strength <= ramp_r;
    end
  end

  // APB decode; zero wait states, so pready is always high.
  assign wr = psel & penable & pwrite;
  assign addr_ok = (paddr == ADDR_CTRL) | (paddr == ADDR_HALF) |
                   (paddr == ADDR_DUTY) | (paddr == ADDR_STAT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = rd_r;

  // Writable registers; a half period below dead time would starve the gates.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      half_r <= HALF_RST;
      duty_r <= DUTY_RST;
    end
    else if (wr)
    begin
      if (paddr == ADDR_CTRL)
        ctrl_r <= pwdata[2:0];
      if (paddr == ADDR_HALF)
        half_r <= pwdata[15:0];
      if (paddr == ADDR_DUTY)
        duty_r <= pwdata[15:0];
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_r <= '0;
    else if (psel && !penable)
    begin
      case (paddr)
        ADDR_CTRL: rd_r <= {29'h0, ctrl_r};
        ADDR_HALF: rd_r <= {16'h0, half_r};
        ADDR_DUTY: rd_r <= {16'h0, duty_r};
        ADDR_STAT: rd_r <= {23'h0, hard_long, sync_lost_r, sync_mode_r,
                            therm_stop_r, ov_stop_r, pin_s.dip_hard, state_r};
        default: rd_r <= '0;
      endcase
    end
  end

endmodule

/* File: dv/ppfs_sequencer_assertions.sv */
// Concurrent checks on the sequencer's switch drives.
`timescale 1ns/1ps
module ppfs_sequencer_chk
  import ppfs_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin flags.
  input wire ppfs_cmp_t cmp_pins,
  // Drives.
  input wire logic first_switch_gate,
  input wire logic second_switch_gate,
  input wire logic drain_hiz,
  input wire logic ss_discharge
);
  logic [7:0] ovn_r;
  logic [7:0] hotn_r;
  logic on_w;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Either gate on.
  assign on_w = first_switch_gate || second_switch_gate;

  // Saturating counts of how long overvoltage and heat have stood at the pins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovn_r <= 8'h00;
      hotn_r <= 8'h00;
    end
    else
    begin
      ovn_r <= cmp_pins.ov_rise ? ovn_r + {7'h00, ovn_r != 8'hFF} : 8'h00;
      hotn_r <= cmp_pins.hot ? hotn_r + {7'h00, hotn_r != 8'hFF} : 8'h00;
    end
  end

  a_gates_exclusive: assert property (!(first_switch_gate && second_switch_gate))
    else $error("both gates on");
  a_dead_time: assert property ($fell(first_switch_gate) |=> !second_switch_gate [*6])
    else $error("dead time short");
  a_hiz_quiet: assert property (drain_hiz |-> !on_w)
    else $error("gate on while drains released");
  a_supply_low_hiz: assert property (!cmp_pins.vcc_ok [*6] |-> drain_hiz)
    else $error("drains driven with supply low");
  a_ov_stop: assert property (ovn_r > 8'h40 |-> !on_w)
    else $error("switching under overvoltage");
  a_heat_stop: assert property (hotn_r > 8'h05 |-> !on_w)
    else $error("switching while hot");
  a_hard_cut: assert property ($rose(cmp_pins.hs1) && cmp_pins.dip_hard
    |-> ##[1:5] !first_switch_gate)
    else $error("hard short not cut");
  a_discharge_off: assert property (ss_discharge |-> !on_w)
    else $error("gate on while discharging");
endmodule

bind ppfs_sequencer ppfs_sequencer_chk ppfs_sequencer_chk_i (
  .pclk(pclk), .presetn(presetn), .cmp_pins(cmp_pins),
  .first_switch_gate(first_switch_gate), .second_switch_gate(second_switch_gate),
  .drain_hiz(drain_hiz), .ss_discharge(ss_discharge)
);

/* File: dv/ppfs_switch_model.sv */
// Behavioural model of the two power switches, their load and a sync source.
`timescale 1ns/1ps
module ppfs_switch_model
  import ppfs_pkg::*;
(
  // Clock and supply state.
  input wire logic pclk,
  input wire logic powered,
  // Gates, load kind (0 normal, 1 soft short, 2 hard short), sync run.
  input wire logic first_switch_gate,
  input wire logic second_switch_gate,
  input wire logic [1:0] load,
  input wire logic clk_run,
  // Flags back to the sequencer.
  output logic ilim1,
  output logic ilim2,
  output logic hs1,
  output logic hs2,
  output logic dip_hard,
  output logic ext_clk
);
  logic [4:0] div_r;

  // A soft short reaches the limit one cycle into each on-phase.
  always_ff @(posedge pclk)
  begin
    ilim1 <= first_switch_gate && load == 2'h1;
    ilim2 <= second_switch_gate && load == 2'h1;
  end

  // A hard short drags the pin and trips the fixed comparator at once.
  assign dip_hard = load == 2'h2;
  assign hs1 = first_switch_gate && dip_hard;
  assign hs2 = second_switch_gate && dip_hard;

  always_ff @(posedge pclk)
    div_r <= clk_run ? div_r + 5'h01 : 5'h00;
  assign ext_clk = powered ? div_r[4] : 1'bz;
endmodule

/* File: dv/ppfs_sequencer_tb.sv */
// Self-checking bench for the sequencer's modes and fault handling.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[FAIL] %s expected %0h seen %0h", n, e, g); \
    end \
  end
module ppfs_sequencer_tb
  import ppfs_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic first_switch_gate;
  logic second_switch_gate;
  logic drain_hiz;
  logic ss_discharge;
  logic [7:0] gate_strength;
  ppfs_cmp_t pins;
  ppfs_cmp_t cmp;
  logic [1:0] load;
  logic clk_run;
  logic powered;
  logic il1, il2, h1, h2, dip, ext;
  logic [31:0] rd;
  logic se;
  int failures;
  int tests_run;
  int n1;
  int n2;
  int n_on;
  int cyc;

  // Short counts keep the run brief.
  ppfs_sequencer #(.HARD_HOLD_CYC(200), .SYNC_LOSS_CYC(200), .SS_STEP_CYC(4)) ppfs_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_pins(cmp), .first_switch_gate(first_switch_gate),
    .second_switch_gate(second_switch_gate), .drain_hiz(drain_hiz),
    .ss_discharge(ss_discharge), .gate_strength(gate_strength)
  );
  ppfs_switch_model ppfs_switch_model_i (
    .pclk(pclk), .powered(powered), .first_switch_gate(first_switch_gate),
    .second_switch_gate(second_switch_gate), .load(load), .clk_run(clk_run),
    .ilim1(il1), .ilim2(il2), .hs1(h1), .hs2(h2), .dip_hard(dip), .ext_clk(ext)
  );

  // The model's flags replace the bench's copies of those fields.
  always_comb
  begin
    cmp = pins;
    cmp.ilim1 = il1;
    cmp.ilim2 = il2;
    cmp.hs1 = h1;
    cmp.hs2 = h2;
    cmp.dip_hard = dip;
    cmp.ext_clk = ext;
  end

  // Free-running clock.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Count gate turn-ons and gate-on cycles inside a window.
  always @(posedge first_switch_gate) n1++;
  always @(posedge second_switch_gate) n2++;
  always @(posedge pclk)
    if (first_switch_gate || second_switch_gate)
      n_on++;

  // Cut a hung run short.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      $display("[FAIL] run expected done seen hang");
      end_sim;
    end
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One bus transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("register", e, rd & m)
  endtask

  task automatic wait_mode(input logic [2:0] m);
    int i;
    for (i = 0; i < 1500; i++)
    begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if (rd[2:0] === m)
        break;
    end
    `CHK("mode", m, rd[2:0])
  endtask

  task automatic window(input int c);
    n1 = 0;
    n2 = 0;
    n_on = 0;
    repeat (c) @(posedge pclk);
  endtask

  // Raise a fault with its release level, then release it in two steps.
  task automatic fault(input int h, input int l, input logic [31:0] b);
    pins[h] <= 1'b1;
    pins[l] <= 1'b1;
    repeat (80) @(posedge pclk);
    window(300);
    `CHK("stop", 0, n1 + n2)
    rchk(ADDR_STAT, b, b);
    pins[h] <= 1'b0;
    window(300);
    `CHK("hold", 0, n1 + n2)
    pins[l] <= 1'b0;
    window(300);
    `CHK("resume", 1'b1, n1 + n2 > 2)
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins = '0;
    load = 2'h0;
    clk_run = 1'b0;
    powered = 1'b0;
    repeat (5) @(posedge pclk);
    powered <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("hiz", 1'b1, drain_hiz)
    `CHK("ready", 1'b1, pready)
    rchk(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rchk(ADDR_HALF, 32'hFFFFFFFF, 32'h32);
    rchk(ADDR_DUTY, 32'hFFFFFFFF, 32'h19);
    apb(1'b1, ADDR_HALF, 32'hFFFF0032);
    rchk(ADDR_HALF, 32'hFFFFFFFF, 32'h32);
    rchk(8'h40, 32'hFFFFFFFF, 32'h0);
    `CHK("slverr", 1'b1, se)
    // Enable held high for less than the filter time leaves the block off; it then stays high.
    pins.enable_input <= 1'b1;
    repeat (300) @(posedge pclk);
    rchk(ADDR_STAT, 32'h7, 32'h0);
    window(700);
    rchk(ADDR_STAT, 32'h7, 32'h1);
    `CHK("drives", 0, n1 + n2)
    pins.vcc_ok <= 1'b1;
    wait_mode(3'h2);
    wait_mode(3'h3);
    `CHK("strength", 8'hFF, gate_strength)
    `CHK("hiz", 1'b0, drain_hiz)
    window(1000);
    `CHK("phases", 1'b1, n1 > 8 && n1 < 12 && n2 > 8 && n2 < 12)
    pins.enable_input <= 1'b0;
    repeat (300) @(posedge pclk);
    pins.enable_input <= 1'b1;
    rchk(ADDR_STAT, 32'h7, 32'h3);
    fault(2, 3, 32'h10);
    fault(4, 5, 32'h20);
    // Heat clears first while overvoltage still stands.
    pins.ov_rise <= 1'b1;
    pins.hot <= 1'b1;
    repeat (100) @(posedge pclk);
    pins.hot <= 1'b0;
    window(300);
    `CHK("both", 0, n1 + n2)
    pins.ov_rise <= 1'b0;
    window(300);
    `CHK("both", 1'b1, n1 + n2 > 2)
    load <= 2'h1;
    window(1000);
    `CHK("retry", 1'b1, n1 > 20 && n2 > 20)
    pins.enable_input <= 1'b0;
    repeat (600) @(posedge pclk);
    pins.enable_input <= 1'b1;
    wait_mode(3'h2);
    window(300);
    `CHK("no limit", 1'b1, n1 < 5)
    load <= 2'h0;
    wait_mode(3'h3);
    load <= 2'h2;
    wait_mode(3'h4);
    `CHK("discharge", 1'b1, ss_discharge)
    `CHK("ramp", 8'h00, gate_strength)
    load <= 2'h0;
    wait_mode(3'h2);
    wait_mode(3'h3);
    // Floating frequency pin with spreading and duty limit requested.
    apb(1'b1, ADDR_CTRL, 32'h6);
    pins.clk_float <= 1'b1;
    repeat (10) @(posedge pclk);
    window(300);
    `CHK("wait ext", 0, n1 + n2)
    clk_run <= 1'b1;
    window(640);
    `CHK("div2", 1'b1, n1 + n2 > 16 && n1 + n2 < 22)
    `CHK("sync on", 1'b1, n_on > 400)
    clk_run <= 1'b0;
    window(400);
    rchk(ADDR_STAT, 32'hC0, 32'hC0);
    pins.clk_float <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h0);
    window(300);
    `CHK("stuck", 0, n1 + n2)
    end_sim;
  end
endmodule
